// ==== dv/ifhz_cpu_model.sv ====
// cpu core model: takes each offered vector, returns after a fixed time
// assumes int_req stands until the ack edge
module ifhz_cpu_model
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic int_req,
	input wire logic slow,
	output logic vec_ack,
	output logic handler_return
);
	int cnt;
	always @(negedge mclk or negedge resetn)
		if (!resetn)
			cnt <= 0;
		else if (cnt != 0 || int_req)
			cnt <= (cnt == 20) ? 0 : cnt + 1;
	assign vec_ack = (cnt == (slow ? 4 : 1));
	assign handler_return = (cnt == 20);
endmodule

// ==== dv/ifhz_ctrl_properties.sv ====
// checker on the controller top ports
// assumes one clock domain, bound into ifhz_ctrl
module ifhz_ctrl_props
	import ifhz_pkg::*;
#(
	parameter int N = IFHZ_NUM_SRC,
	parameter int LW = IFHZ_LVL_W
)
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [N-1:0] src_event,
	input wire logic [N-1:0] src_enable,
	input wire logic [N*LW-1:0] src_level,
	input wire logic nested_mode,
	input wire logic [N-1:0] flag_clear,
	input wire logic restore_condition_codes_instr,
	input wire logic int_req,
	input wire logic [IFHZ_VEC_W-1:0] vec_addr,
	input wire logic global_mask,
	input wire logic unwanted_reset,
	input wire logic in_handler,
	input wire logic [LW-1:0] run_level
);
	logic lvl_ok;
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!resetn);
	// clears from a handler of lower level are the only unsafe in-handler case
	always_comb
	begin
		lvl_ok = 1'b1;
		for (int i = 0; i < N; i++)
			if (flag_clear[i] && run_level < src_level[i*LW+:LW])
				lvl_ok = 1'b0;
	end
	property p_mask; $rose(int_req) |-> !$past(global_mask); endproperty
	a_mask: assert property (p_mask) else $error("request while masked");
	property p_vec;
		$rose(int_req) |-> (vec_addr == IFHZ_VEC_RESET) == $past(restore_condition_codes_instr);
	endproperty
	a_vec: assert property (p_vec) else $error("wrong vector");
	property p_haz;
		|(flag_clear & src_event & src_enable) && !global_mask && !in_handler |=> unwanted_reset;
	endproperty
	a_haz: assert property (p_haz) else $error("hazard missed");
	property p_en; (flag_clear & src_event & src_enable) == '0 |=> !unwanted_reset; endproperty
	a_en: assert property (p_en) else $error("reset without cause");
	property p_conc; in_handler && !nested_mode |=> !unwanted_reset; endproperty
	a_conc: assert property (p_conc) else $error("reset in handler");
	property p_nest; in_handler && lvl_ok |=> !unwanted_reset; endproperty
	a_nest: assert property (p_nest) else $error("reset at safe level");
endmodule
bind ifhz_ctrl ifhz_ctrl_props #(.N(N), .LW(LW)) props_u (.*);

// ==== dv/ifhz_ctrl_tb.sv ====
// bench for the flag clear hazard controller
// assumes the cpu model answers every vector
module ifhz_ctrl_tb;
	import ifhz_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, resetn = 1'b0, nested_mode = 1'b0, slow = 1'b0, restored_mask = 1'b0;
	logic set_global_mask_instr = 1'b0, clear_global_mask_instr = 1'b0;
	logic save_condition_codes_instr = 1'b0, restore_condition_codes_instr = 1'b0;
	logic [3:0] src_event = 4'h0, flag_clear = 4'h0, src_enable = 4'hF, vec_addr, pending;
	logic [7:0] src_level = 8'hD8;
	logic int_req, global_mask, unwanted_reset, in_handler, saved_mask, vec_ack, handler_return;
	logic [1:0] run_level;
	int error_cnt = 0, tests_run = 0, cyc = 0;
	// row bits: nested, mask first, enable kept, reset expected
	logic [3:0] rows [6] = '{4'h3, 4'h0, 4'h6, 4'hB, 4'hE, 4'h8};
	ifhz_ctrl dut_u (.*);
	ifhz_cpu_model cpu_u (.*);
	initial forever #50 mclk = ~mclk;
	task automatic chk(input string n, input logic [3:0] e, input logic [3:0] s);
		tests_run++;
		if (s !== e)
		begin
			$display("[ERR] %s exp %h got %h", n, e, s);
			error_cnt++;
		end
	endtask
	task automatic hz(input int i, input logic e);
		src_event[i] = 1'b1;
		flag_clear[i] = 1'b1;
		@(negedge mclk);
		src_event = 4'h0;
		flag_clear = 4'h0;
		chk("unwanted_reset", 4'(e), 4'(unwanted_reset));
		@(negedge mclk);
	endtask
	// clears while disabled, so draining can never raise a reset itself
	task automatic drain;
		src_enable = 4'h0;
		flag_clear = 4'hF;
		clear_global_mask_instr = 1'b1;
		@(negedge mclk);
		src_enable = 4'hF;
		flag_clear = 4'h0;
		clear_global_mask_instr = 1'b0;
		while ((int_req || in_handler) && cyc < 3000)
			@(negedge mclk);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			final_report;
		end
	end
	initial
	begin
		repeat (16) @(negedge mclk);
		chk("global_mask", 4'h1, 4'(global_mask));
		resetn = 1'b1;
		drain;
		$display("reset done");
		foreach (rows[i])
		begin
			nested_mode = rows[i][3];
			save_condition_codes_instr = rows[i][2];
			set_global_mask_instr = rows[i][2];
			@(negedge mclk);
			save_condition_codes_instr = 1'b0;
			set_global_mask_instr = 1'b0;
			src_enable[2] = rows[i][1];
			hz(2, rows[i][0]);
			chk("pending", 4'h4, pending);
			drain;
			$display("row %0d done", i);
		end
		chk("saved_mask", 4'h0, 4'(saved_mask));
		slow = 1'b1;
		src_event[1] = 1'b1;
		@(negedge mclk);
		src_event[1] = 1'b0;
		restore_condition_codes_instr = 1'b1;
		@(negedge mclk);
		restore_condition_codes_instr = 1'b0;
		chk("vec_addr", IFHZ_VEC_RESET, vec_addr);
		drain;
		set_global_mask_instr = 1'b1;
		src_event[1] = 1'b1;
		@(negedge mclk);
		set_global_mask_instr = 1'b0;
		src_event[1] = 1'b0;
		restore_condition_codes_instr = 1'b1;
		@(negedge mclk);
		restore_condition_codes_instr = 1'b0;
		chk("int_req", 4'h0, 4'(int_req));
		@(negedge mclk);
		chk("vec_addr", 4'h1, vec_addr);
		drain;
		$display("restore done");
		nested_mode = 1'b1;
		src_event[1] = 1'b1;
		@(negedge mclk);
		src_event[1] = 1'b0;
		while (!in_handler && cyc < 3000)
			@(negedge mclk);
		chk("run_level", 4'h2, 4'(run_level));
		chk("global_mask", 4'h1, 4'(global_mask));
		clear_global_mask_instr = 1'b1;
		@(negedge mclk);
		clear_global_mask_instr = 1'b0;
		hz(2, 1'b0);
		hz(3, 1'b1);
		drain;
		$display("nested done");
		src_event[0] = 1'b1;
		@(negedge mclk);
		src_event[0] = 1'b0;
		resetn = 1'b0;
		@(negedge mclk);
		chk("pending", 4'h0, pending);
		chk("global_mask", 4'h1, 4'(global_mask));
		chk("vec_addr", IFHZ_VEC_RESET, vec_addr);
		resetn = 1'b1;
		@(negedge mclk);
		@(negedge mclk);
		chk("int_req", 4'h0, 4'(int_req));
		$display("reset again done");
		final_report;
	end
endmodule

// ==== inc/ifhz_pkg.sv ====
// package for the interrupt controller with flag clear hazards
// assumes a single clock domain and synchronous inputs
package ifhz_pkg;
	localparam int IFHZ_NUM_SRC = 4;
	localparam int IFHZ_LVL_W = 2;
	localparam int IFHZ_VEC_W = 4;
	localparam logic [3:0] IFHZ_VEC_RESET = 4'hF;
	localparam logic [3:0] IFHZ_VEC_BASE = 4'h0;
	localparam logic [1:0] IFHZ_LVL_MAIN = 2'h0;
	typedef enum logic [1:0]
	{
		IFHZ_ST_IDLE = 2'b00,
		IFHZ_ST_VEC = 2'b01,
		IFHZ_ST_SERVE = 2'b10
	} ifhz_state_e;
endpackage

// ==== inc/ifhz_req_if.sv ====
// request arbitration signals between the controller and its arbiter
// assumes one source per bit, index 0 highest priority on level ties
interface ifhz_req_if #(parameter int N = 4, parameter int LW = 2);
	logic [N-1:0] active;
	logic [N*LW-1:0] level;
	logic found;
	logic [$clog2(N)-1:0] winner;
	logic [LW-1:0] win_level;
	modport ctl (output active, output level, input found, input winner, input win_level);
	modport arb (input active, input level, output found, output winner, output win_level);
endinterface

// ==== verilog/ifhz_arbiter.sv ====
// priority arbiter: highest level wins, lowest index on a tie
// assumes combinational use inside the controller
module ifhz_arbiter
	import ifhz_pkg::*;
#(
	parameter int N = IFHZ_NUM_SRC,
	parameter int LW = IFHZ_LVL_W
)
(
	ifhz_req_if.arb req
);
	always_comb
	begin
		req.found = 1'b0;
		req.winner = '0;
		req.win_level = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (req.active[i] && (!req.found || req.level[i*LW +: LW] >= req.win_level))
			begin
				req.found = 1'b1;
				req.winner = i[$clog2(N)-1:0];
				req.win_level = req.level[i*LW +: LW];
			end
		end
	end
endmodule

// ==== verilog/ifhz_ctrl.sv ====
// nested interrupt controller modelling vector fetch and flag clear hazards
// assumes the cpu core reports instruction events as one-cycle pulses
//
// Summary of operation
// RULE1: a request taken while the condition codes are being restored yields the reset vector.
// RULE2: software sets the global mask right before restoring the condition codes.
// RULE3: a request live in the same cycle its pending flag is cleared raises an unwanted reset.
// RULE4: clearing an enable bit never raises the unwanted reset.
// RULE5: in concurrent mode a clear inside any handler or while the source is disabled is safe.
// RULE6: in nested mode a clear is safe in its own handler, one of higher or equal level, or disabled.
// RULE7: in concurrent mode software brackets risky clears with mask set and mask clear.
// RULE8: in nested mode software saves codes, sets mask, clears, then restores codes.
// RULE9: while the global mask is set no maskable request is presented to the cpu; the code only blocks new takes, int_req stays up until vec_ack.
module ifhz_ctrl
	import ifhz_pkg::*;
#(
	parameter int N = IFHZ_NUM_SRC,
	parameter int LW = IFHZ_LVL_W
)
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [N-1:0] src_event,
	input wire logic [N-1:0] src_enable,
	input wire logic [N*LW-1:0] src_level,
	input wire logic nested_mode,
	input wire logic [N-1:0] flag_clear,
	input wire logic set_global_mask_instr,
	input wire logic clear_global_mask_instr,
	input wire logic save_condition_codes_instr,
	input wire logic restore_condition_codes_instr,
	input wire logic restored_mask,
	input wire logic vec_ack,
	input wire logic handler_return,
	output logic int_req,
	output logic [IFHZ_VEC_W-1:0] vec_addr,
	output logic global_mask,
	output logic [N-1:0] pending,
	output logic unwanted_reset,
	output logic in_handler,
	output logic [LW-1:0] run_level,
	output logic saved_mask
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	ifhz_state_e state_r;
	logic [N-1:0] pend_r;
	logic mask_r;
	logic saved_r;
	logic [IFHZ_VEC_W-1:0] vec_r;
	logic rst_r;
	logic [LW-1:0] lvl_r;
	logic serving_r;
	logic [LW-1:0] take_lvl_r;
	logic [N-1:0] active;
	logic [N-1:0] hazard;
	logic [N-1:0] safe;

	ifhz_req_if #(.N(N), .LW(LW)) req ();
	ifhz_arbiter #(.N(N), .LW(LW)) u_arb (.req(req.arb));

	assign active = pend_r & src_enable;
	assign req.active = active;
	assign req.level = src_level;

	// ----------------------------------------
	// flag clear hazard detection
	// ----------------------------------------
	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			// inside a handler: any handler in concurrent mode, equal or higher level nested
			safe[i] = !src_enable[i] || (serving_r && (!nested_mode || lvl_r >= src_level[i*LW +: LW])); // see RULE5 see RULE6
			hazard[i] = flag_clear[i] && src_event[i] && !safe[i] && !mask_r; // see RULE3
		end
	end

	// enable bits feed only `safe`; dropping one cannot build a hazard
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			rst_r <= 1'b0;
		else
			rst_r <= |hazard; // see RULE4
	end

	// ----------------------------------------
	// pending flags, set wins over clear
	// ----------------------------------------
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			pend_r <= '0;
		else
			pend_r <= (pend_r & ~flag_clear) | src_event;
	end

	// ----------------------------------------
	// condition code mask and stack copy
	// ----------------------------------------
	// a restore outranks every other mask update, so a masked pop cannot be
	// undone by a vector ack or return landing in the same cycle
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			saved_r <= 1'b1;
		else if (save_condition_codes_instr)
			saved_r <= mask_r;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			mask_r <= 1'b1;
		else if (restore_condition_codes_instr)
			mask_r <= restored_mask;
		else if (set_global_mask_instr)
			mask_r <= 1'b1;
		else if (clear_global_mask_instr)
			mask_r <= 1'b0;
		else if (state_r == IFHZ_ST_VEC && vec_ack)
			mask_r <= 1'b1;
		else if (handler_return)
			mask_r <= 1'b0;
	end

	// ----------------------------------------
	// vector delivery
	// ----------------------------------------
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= IFHZ_ST_IDLE;
			vec_r <= IFHZ_VEC_RESET;
		end
		else
		begin
			unique case (state_r)
				IFHZ_ST_IDLE:
				begin
					// no new take while masked: no vector can meet a masked restore
					if (req.found && !mask_r) // see RULE9
					begin
						state_r <= IFHZ_ST_VEC;
						// source is lost when a restore runs as the request is taken
						if (restore_condition_codes_instr) // see RULE1
							vec_r <= IFHZ_VEC_RESET;
						else
							vec_r <= IFHZ_VEC_BASE + IFHZ_VEC_W'(req.winner);
					end
				end
				IFHZ_ST_VEC:
					if (vec_ack)
						state_r <= IFHZ_ST_SERVE;
				IFHZ_ST_SERVE:
					if (handler_return)
						state_r <= IFHZ_ST_IDLE;
				default:
					state_r <= IFHZ_ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// level of the request being taken
	// ----------------------------------------
	// the arbiter may move on between take and ack, so the level is held
	// from the take edge; a later higher request must not lift the handler
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			take_lvl_r <= IFHZ_LVL_MAIN;
		else if (state_r == IFHZ_ST_IDLE && req.found && !mask_r)
		begin
			// a lost source runs at main level
			if (restore_condition_codes_instr)
				take_lvl_r <= IFHZ_LVL_MAIN;
			else
				take_lvl_r <= req.win_level;
		end
	end

	// ----------------------------------------
	// serving context
	// ----------------------------------------
	// one handler level is kept; nesting depth beyond one is not tracked,
	// a return always drops back to main level
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			serving_r <= 1'b0;
			lvl_r <= IFHZ_LVL_MAIN;
		end
		else if (state_r == IFHZ_ST_VEC && vec_ack)
		begin
			serving_r <= 1'b1;
			lvl_r <= take_lvl_r;
		end
		else if (handler_return)
		begin
			serving_r <= 1'b0;
			lvl_r <= IFHZ_LVL_MAIN;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// int_req is decoded from the state register, so it carries no glitch
	assign int_req = (state_r == IFHZ_ST_VEC);
	assign vec_addr = vec_r;
	assign global_mask = mask_r;
	assign pending = pend_r;
	assign unwanted_reset = rst_r;
	assign in_handler = serving_r;
	assign run_level = lvl_r;
	assign saved_mask = saved_r;
endmodule
